// ### include/mps_pkg.sv
// constants and types shared by the mode, power and slow-control register block
package mps_pkg;

   // ---------------------------------------------------------------
   // command targets and the read type modifier
   // ---------------------------------------------------------------
   localparam logic [15:0] MPS_MODE_ADDR = 16'h0006;
   localparam logic [15:0] MPS_PULSE_ADDR = 16'h0008;
   localparam logic [15:0] MPS_LOAD_ADDR = 16'h000A;
   localparam logic [15:0] MPS_READ_MOD = 16'h1000;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int MPS_SLEEP_BIT = 0;
   localparam int MPS_IDLE_BIT = 1;
   localparam int MPS_SYNC_BIT = 2;
   localparam int MPS_LOOP_BIT = 3;
   localparam int MPS_STATE_LSB = 4;
   localparam int MPS_SLAB_BIT = 5;
   localparam int MPS_LOAD_BIT = 0;
   localparam int MPS_CRC_BIT = 1;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] MPS_REQ_RST = 4'h0;
   localparam logic [5:0] MPS_PULSE_RST = 6'h00;
   localparam logic MPS_LOAD_RST = 1'b0;
   localparam logic MPS_CRC_RST = 1'b0;

   // ---------------------------------------------------------------
   // operating state codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MPS_ST_SLEEP = 3'h0,
      MPS_ST_IDLE = 3'h1,
      MPS_ST_SYNC = 3'h2,
      MPS_ST_LOOP = 3'h3
   } mps_state_t;

endpackage

// ### hdl/mps_sync.sv
// two-flop synchroniser for a group of link-side inputs
`timescale 1ns/1ps
module mps_sync #(
   parameter int WIDTH = 1
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // asynchronous input and synchronised output
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_sync;

   // first stage feeds only the second stage
   always_comb begin
      next_stage1 = ce_i ? async_i : stage1;
      next_sync = ce_i ? stage1 : sync_o;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         stage1 <= '0;
         sync_o <= '0;
      end else begin
         stage1 <= next_stage1;
         sync_o <= next_sync;
      end
   end
endmodule // mps_sync

// ### hdl/mps_regs.sv
// mode, supply pulse and slow-control load registers behind block and fast commands
// Summary of operation
// - read-only three-bit state code shows last accepted mode: 0 sleep,1 idle,2 sync,3 loop.
// - fast loop request sets bit 3, accepted into loop state 011, then self-clears.
// - fast sync request sets bit 2, accepted into sync state 010, then self-clears.
// - writing 0x0002 requests idle; bit self-clears and state becomes 001.
// - writing 0x0001 to mode register requests sleep; bit self-clears, state 000.
// - zero request bits never change the operating state.
// - mode register at 0x0006, supply pulse at 0x0008, load register at 0x000A.
// - acquisition start command switches whole slab power on before data taking.
// - slab bit 5 switches all five supply lines on; clearing it leaves each line to its own bit and acquisition power.
// - bit 4 drives dac line, bit 3 drives adc line.
// - bit 2 drives sample store line, bit 1 digital, bit 0 analog.
// - a cleared pulse bit switches its supply line off unless slab bit 5 or acquisition power is on.
// - crc flag bit 1 reads 1 when last transfer checked good, else 0.
// - writing 0x0001 starts a load; device clears the bit when the load completes.
// - a command with modifier 0x1000 returns the addressed register contents.
// - a started operation is not interrupted by later commands; device returns automatically. here only a load does; sync and loop stay until a new request.
`timescale 1ns/1ps
module mps_regs
   import mps_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // link side, synchronised on clk_i, words taken on a rising link clock edge
   input wire logic link_clk_i,
   input wire logic bt_valid_i,
   input wire logic [15:0] bt_command_i,
   input wire logic [15:0] bt_modifier_i,
   input wire logic fast_loop_i,
   input wire logic fast_sync_i,
   input wire logic acq_start_i,
   // slow-control load engine, same clock
   input wire logic load_done_i,
   input wire logic crc_pass_i,
   // read answer
   output logic rd_valid_o,
   output logic [15:0] rd_data_o,
   // status and supply controls
   output logic [2:0] state_code_o,
   output logic load_active_o,
   output logic crc_ok_o,
   output logic [4:0] pwr_lines_o
);

   // ---------------------------------------------------------------
   // link input synchronisation and edge detection
   // ---------------------------------------------------------------
   localparam int SYNC_W = 37;
   logic [SYNC_W-1:0] link_sync;
   logic link_clk_s, link_clk_d, next_link_clk_d;
   logic cmd_valid, fast_loop, fast_sync, acq_start;
   logic [15:0] cmd_addr, cmd_mod;
   logic take;

   mps_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .async_i({link_clk_i, bt_valid_i, bt_command_i, bt_modifier_i,
                fast_loop_i, fast_sync_i, acq_start_i}),
      .sync_o(link_sync)
   );

   // unpack synchronised link inputs
   assign {link_clk_s, cmd_valid, cmd_addr, cmd_mod, fast_loop, fast_sync, acq_start} = link_sync;
   assign take = ce_i && link_clk_s && !link_clk_d; // rising link edge

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [3:0] mode_req, next_mode_req;
   mps_state_t state, next_state;
   logic [5:0] pulse, next_pulse;
   logic load_go, next_load_go;
   logic crc_ok, next_crc_ok;
   logic acq_power, next_acq_power;
   logic next_rd_valid;
   logic [15:0] next_rd_data;
   logic [4:0] next_pwr;
   logic wr_take, rd_take;
   logic [15:0] read_word_w;
   logic [4:0] pwr_expect;

   // register contents as seen by a read, reserved bits zero
   function automatic logic [15:0] read_word(input logic [15:0] addr);
      logic [15:0] w;
      w = 16'h0000;
      if (addr == MPS_MODE_ADDR) begin
         w[MPS_STATE_LSB +: 3] = state;
         w[3:0] = mode_req;
      end else if (addr == MPS_PULSE_ADDR) begin
         w[5:0] = pulse;
      end else if (addr == MPS_LOAD_ADDR) begin
         w[MPS_CRC_BIT] = crc_ok;
         w[MPS_LOAD_BIT] = load_go;
      end
      return w;
   endfunction

   assign wr_take = take && cmd_valid && (cmd_mod != MPS_READ_MOD);
   assign rd_take = take && cmd_valid && (cmd_mod == MPS_READ_MOD);
   // always_comb so the decode follows the register state that the function reads
   always_comb read_word_w = read_word(cmd_addr);
   assign pwr_expect = pulse[4:0] | {5{pulse[MPS_SLAB_BIT] | acq_power}};

   // next values of all register state
   always_comb begin
      next_link_clk_d = ce_i ? link_clk_s : link_clk_d;
      next_mode_req = mode_req;
      next_state = state;
      next_pulse = pulse;
      next_load_go = load_go;
      next_crc_ok = crc_ok;
      next_acq_power = acq_power;
      next_rd_valid = rd_valid_o; // frozen while the enable is low
      next_rd_data = rd_data_o;
      next_pwr = pwr_lines_o;
      if (ce_i) begin
         next_rd_valid = 1'b0; // answer stands one enabled cycle
         // accept a pending request, loop first, then self-clear
         if (mode_req[MPS_LOOP_BIT]) begin
            next_state = MPS_ST_LOOP;
         end else if (mode_req[MPS_SYNC_BIT]) begin
            next_state = MPS_ST_SYNC;
         end else if (mode_req[MPS_IDLE_BIT]) begin
            next_state = MPS_ST_IDLE;
         end else if (mode_req[MPS_SLEEP_BIT]) begin
            next_state = MPS_ST_SLEEP;
            next_acq_power = 1'b0;
         end
         next_mode_req = MPS_REQ_RST; // zero bits change nothing
         // load completion clears the start bit and latches the crc result
         if (load_done_i) begin
            next_load_go = 1'b0;
            next_crc_ok = crc_pass_i;
         end
         // new requests; a set wins over the clear above
         if (take && fast_loop) next_mode_req[MPS_LOOP_BIT] = 1'b1;
         if (take && fast_sync) next_mode_req[MPS_SYNC_BIT] = 1'b1;
         if (take && acq_start) next_acq_power = 1'b1;
         if (wr_take && cmd_addr == MPS_MODE_ADDR) begin
            if (cmd_mod[MPS_IDLE_BIT]) next_mode_req[MPS_IDLE_BIT] = 1'b1;
            if (cmd_mod[MPS_SLEEP_BIT]) next_mode_req[MPS_SLEEP_BIT] = 1'b1;
         end else if (wr_take && cmd_addr == MPS_PULSE_ADDR) begin
            next_pulse = cmd_mod[5:0]; // reserved bits dropped
         end else if (wr_take && cmd_addr == MPS_LOAD_ADDR) begin
            // a running load is not restarted
            // a load finishing in this cycle may be restarted: the set wins
            if (cmd_mod[MPS_LOAD_BIT] && (!load_go || load_done_i)) next_load_go = 1'b1;
         end
         // read answer one cycle after the command is taken
         if (rd_take) begin
            next_rd_valid = 1'b1;
            next_rd_data = read_word_w;
         end
         // supply lines: own bit, whole slab bit or acquisition power
         next_pwr = pwr_expect;
      end
   end

   // register everything
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         link_clk_d <= 1'b0;
         mode_req <= MPS_REQ_RST;
         state <= MPS_ST_SLEEP;
         pulse <= MPS_PULSE_RST;
         load_go <= MPS_LOAD_RST;
         crc_ok <= MPS_CRC_RST;
         acq_power <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= 16'h0000;
         pwr_lines_o <= 5'h00;
      end else begin
         link_clk_d <= next_link_clk_d;
         mode_req <= next_mode_req;
         state <= next_state;
         pulse <= next_pulse;
         load_go <= next_load_go;
         crc_ok <= next_crc_ok;
         acq_power <= next_acq_power;
         rd_valid_o <= next_rd_valid;
         rd_data_o <= next_rd_data;
         pwr_lines_o <= next_pwr;
      end
   end

   // status outputs straight from flops
   assign state_code_o = state;
   assign load_active_o = load_go;
   assign crc_ok_o = crc_ok;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_loop_pend;
      ce_i && mode_req[MPS_LOOP_BIT];
   endsequence
   sequence s_sleep_write;
      ce_i && wr_take && cmd_addr == MPS_MODE_ADDR && cmd_mod == 16'h0001
         && !fast_loop && !fast_sync;
   endsequence

   a_loop_accept: assert property (s_loop_pend |=> state == MPS_ST_LOOP)
      else $error("loop request not accepted");
   a_sync_accept: assert property (ce_i && mode_req == 4'h4 |=> state == MPS_ST_SYNC)
      else $error("sync request not accepted");
   a_idle_accept: assert property (ce_i && mode_req == 4'h2 |=> state == MPS_ST_IDLE)
      else $error("idle request not accepted");
   a_sleep_write: assert property (s_sleep_write ##1 ce_i |=> state == MPS_ST_SLEEP)
      else $error("sleep write did not reach sleep state");
   a_state_hold: assert property (mode_req == 4'h0 |=> $stable(state))
      else $error("state changed without request");
   a_req_clear: assert property (s_loop_pend and !take |=> !mode_req[MPS_LOOP_BIT])
      else $error("loop request did not self-clear");
   a_slab_all: assert property (ce_i && pulse[MPS_SLAB_BIT] |=> pwr_lines_o == 5'h1F)
      else $error("slab bit did not switch all lines");
   a_pwr_lines: assert property (ce_i |=> pwr_lines_o == $past(pwr_expect))
      else $error("supply lines do not follow pulse bits");
   a_acq_power: assert property (ce_i && take && acq_start ##1 ce_i
      |=> pwr_lines_o == 5'h1F)
      else $error("acquisition start left slab unpowered");
   a_read_reply: assert property (rd_take
      |=> rd_valid_o && rd_data_o == $past(read_word_w))
      else $error("read answer missing or wrong");
   a_load_done: assert property (ce_i && load_done_i && !wr_take
      |=> !load_go && crc_ok == $past(crc_pass_i))
      else $error("load bit or crc flag not updated on completion");
   a_reserved_zero: assert property (rd_valid_o |-> rd_data_o[15:7] == 9'h000)
      else $error("reserved bits read nonzero");

endmodule // mps_regs

// ### sim/mps_ctrl_model.sv
// link controller model: free link clock, block commands and fast commands
`timescale 1ns/1ps
module mps_ctrl_model (
   // link outputs towards the device
   output logic link_clk_o,
   output logic bt_valid_o,
   output logic [15:0] bt_command_o,
   output logic [15:0] bt_modifier_o,
   output logic fast_loop_o,
   output logic fast_sync_o,
   output logic acq_start_o
);
   // the device takes words on rising edges of this clock, so it never stops
   initial link_clk_o = 1'b0;
   always #24 link_clk_o = ~link_clk_o;

   // quiet link at time zero
   initial begin
      bt_valid_o = 1'b0;
      bt_command_o = 16'h0000;
      bt_modifier_o = 16'h0000;
      {fast_loop_o, fast_sync_o, acq_start_o} = 3'h0;
   end

   // one word held across a link rising edge, then released
   task automatic send(input logic v, input logic [15:0] a, input logic [15:0] d,
         input logic [2:0] f);
      @(negedge link_clk_o);
      bt_valid_o = v;
      bt_command_o = a;
      bt_modifier_o = d;
      {fast_loop_o, fast_sync_o, acq_start_o} = f;
      @(negedge link_clk_o);
      bt_valid_o = 1'b0;
      bt_command_o = ~a; // released lines show no stale word
      bt_modifier_o = ~d;
      {fast_loop_o, fast_sync_o, acq_start_o} = 3'h0;
   endtask
endmodule // mps_ctrl_model

// ### sim/mps_regs_bench.sv
// self-checking bench for the mode, supply pulse and load registers
`timescale 1ns/1ps
module mps_regs_bench;
   import mps_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ce_i = 1'b1;
   logic load_done_i = 1'b0;
   logic crc_pass_i = 1'b0;
   logic link_clk, bt_valid, fl, fs, acq;
   logic [15:0] bt_cmd, bt_mod, rd_data_o, d;
   logic rd_valid_o, load_active_o, crc_ok_o;
   logic [2:0] state_code_o;
   logic [4:0] pwr_lines_o;
   logic [15:0] exp_q[$];
   int err_count = 0;
   int check_count = 0;
   int seed;

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   mps_ctrl_model u_mps_ctrl_model (.link_clk_o(link_clk), .bt_valid_o(bt_valid),
      .bt_command_o(bt_cmd), .bt_modifier_o(bt_mod), .fast_loop_o(fl),
      .fast_sync_o(fs), .acq_start_o(acq));

   mps_regs u_mps_regs (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
      .link_clk_i(link_clk), .bt_valid_i(bt_valid), .bt_command_i(bt_cmd),
      .bt_modifier_i(bt_mod), .fast_loop_i(fl), .fast_sync_i(fs), .acq_start_i(acq),
      .load_done_i(load_done_i), .crc_pass_i(crc_pass_i), .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o), .state_code_o(state_code_o),
      .load_active_o(load_active_o), .crc_ok_o(crc_ok_o), .pwr_lines_o(pwr_lines_o));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one link word, then let the update settle
   task automatic go(input logic v, input logic [15:0] a, input logic [15:0] dat,
         input logic [2:0] f);
      u_mps_ctrl_model.send(v, a, dat, f);
      repeat (4) @(negedge clk_i);
   endtask

   // read: the expected word is noted before the request leaves
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      go(1'b1, a, MPS_READ_MOD, 3'h0);
   endtask

   task automatic mode(input logic [2:0] st);
      check({13'h0000, state_code_o}, {13'h0000, st});
      rd(MPS_MODE_ADDR, {9'h000, st, 4'h0});
   endtask

   // read answer monitor takes the oldest note
   always @(negedge clk_i) begin
      if (rd_valid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_count++;
            $display("ERROR %0t unexpected read answer", $time);
         end else begin
            check(rd_data_o, exp_q.pop_front());
         end
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = $urandom(74);
      repeat (6) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge clk_i);
      mode(MPS_ST_SLEEP);
      rd(MPS_PULSE_ADDR, 16'h0000);
      rd(MPS_LOAD_ADDR, 16'h0000);
      rd(16'h000C, 16'h0000);
      // mode requests by block write and fast command
      go(1'b1, MPS_MODE_ADDR, 16'h0002, 3'h0);
      mode(MPS_ST_IDLE);
      go(1'b1, MPS_MODE_ADDR, 16'hFF8C, 3'h0);
      mode(MPS_ST_IDLE);
      go(1'b0, 16'h0000, 16'h0000, 3'h2);
      mode(MPS_ST_SYNC);
      go(1'b0, 16'h0000, 16'h0000, 3'h4);
      mode(MPS_ST_LOOP);
      go(1'b1, MPS_MODE_ADDR, 16'h0001, 3'h0);
      mode(MPS_ST_SLEEP);
      go(1'b0, 16'h0000, 16'h0000, 3'h6);
      mode(MPS_ST_LOOP);
      // supply switches: corners, then random words
      for (int i = 0; i < 20; i++) begin
         d = (i == 0) ? 16'h0020 : (i == 1) ? 16'h0000 : 16'($urandom());
         if (d == MPS_READ_MOD) d = 16'h003F; // the read modifier never writes
         go(1'b1, MPS_PULSE_ADDR, d, 3'h0);
         check({11'h000, pwr_lines_o}, {11'h000, d[4:0] | {5{d[5]}}});
         rd(MPS_PULSE_ADDR, {10'h000, d[5:0]});
      end
      go(1'b1, MPS_PULSE_ADDR, 16'h0000, 3'h0);
      go(1'b0, 16'h0000, 16'h0000, 3'h1);
      check({11'h000, pwr_lines_o}, 16'h001F);
      go(1'b1, MPS_MODE_ADDR, 16'h0001, 3'h0);
      check({11'h000, pwr_lines_o}, 16'h0000);
      // load start and completion with good then bad check
      for (int k = 0; k < 2; k++) begin
         go(1'b1, MPS_LOAD_ADDR, 16'h0001, 3'h0);
         check({15'h0000, load_active_o}, 16'h0001);
         rd(MPS_LOAD_ADDR, {14'h0000, 1'(k == 1), 1'b1});
         load_done_i = 1'b1;
         crc_pass_i = 1'(k == 0);
         @(negedge clk_i);
         load_done_i = 1'b0;
         crc_pass_i = 1'b0;
         repeat (2) @(negedge clk_i);
         check({14'h0000, crc_ok_o, load_active_o}, {14'h0000, 1'(k == 0), 1'b0});
         rd(MPS_LOAD_ADDR, {14'h0000, 1'(k == 0), 1'b0});
      end
      // enable low freezes a load completion until it returns
      go(1'b1, MPS_LOAD_ADDR, 16'h0001, 3'h0);
      check({14'h0000, crc_ok_o, load_active_o}, 16'h0001);
      ce_i = 1'b0;
      load_done_i = 1'b1;
      crc_pass_i = 1'b1;
      repeat (2) @(negedge clk_i);
      check({14'h0000, crc_ok_o, load_active_o}, 16'h0001);
      ce_i = 1'b1;
      @(negedge clk_i);
      load_done_i = 1'b0;
      crc_pass_i = 1'b0;
      @(negedge clk_i);
      check({14'h0000, crc_ok_o, load_active_o}, 16'h0002);
      repeat (10) @(negedge clk_i);
      report_and_stop();
   end

   // watchdog against a hang
   initial begin
      #40000;
      err_count++;
      report_and_stop();
   end
endmodule // mps_regs_bench
